// >>> logic/fe_status_pkg.sv
package fe_status_pkg;

  // Register map, byte addresses on the 24-bit register port
  localparam logic [23:0] CTRL_ADDR  = 24'h224001;
  localparam logic [23:0] STAT0_ADDR = 24'h224002;
  localparam logic [23:0] STAT1_ADDR = 24'h224003;

  // Control register fields
  localparam int START_BIT  = 7;
  localparam int PAGE_BIT   = 6;
  localparam int CHIP_BIT   = 5;
  localparam int IRQSEL_BIT = 1;
  localparam int BUSY_BIT   = 0;

  // Status register 0 and 1 fields
  localparam int ERR_BIT        = 7;
  localparam int SECT_MSB       = 6;
  localparam int ERASE_FAIL_BIT = 7;
  localparam int PROG_FAIL_BIT  = 6;
  localparam int SWAP_FAIL_BIT  = 5;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] STAT0_RST = 8'h00;
  localparam logic [7:0] STAT1_RST = 8'h00;

  // Byte returned by a blocked memory read
  localparam logic [7:0] BLANK_BYTE = 8'hFF;

  // Power-up / power-down exit not-ready window
  localparam int CLK_MHZ       = 250;
  localparam int READY_TIME_MS = 10;
  localparam int READY_CYCLES  = READY_TIME_MS * CLK_MHZ * 1000;

  // Engine sector vector: [5:0] F5..F0, [7:6] eeprom, [8] testflash/OTP
  localparam int SECT_IN_W = 9;

  typedef enum logic [1:0] {EE_IDLE, EE_WAIT_LATCH, EE_BUSY} eep_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
  } mem_req_t;

  typedef struct packed {
    logic                 erase_fail;
    logic                 program_fail;
    logic                 overwrite_fail;
    logic                 prot_op;
    logic                 swap_fail;
    logic [SECT_IN_W-1:0] sectors;
  } fail_evt_t;

  // Folds engine sectors into the seven status bits
  function automatic logic [6:0] map_sectors(
    input logic [SECT_IN_W-1:0] s,
    input logic                 big
  );
    logic [6:0] m;
    m = {s[8], s[7], s[6], s[3:0]};
    if (big) begin
      m[3] = s[5] | s[4] | s[3];
    end
    return m;
  endfunction

endpackage

// >>> logic/ready_timer.sv
`timescale 1ns/1ns
module ready_timer
  import fe_status_pkg::*;
#(
  parameter int CNT = READY_CYCLES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Restart on power-down exit
  input  wire logic restart_in,
  // Not-ready level
  output logic      busy_out
);

  localparam int W = $clog2(CNT + 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_busy;

  always_comb begin
    next_cnt  = cnt;
    next_busy = busy_out;
    if (restart_in) begin
      next_cnt  = W'(CNT - 1);
      next_busy = 1'b1;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end else begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt      <= W'(CNT - 1);
      busy_out <= 1'b1;
    end else begin
      cnt      <= next_cnt;
      busy_out <= next_busy;
    end
  end

endmodule

// >>> logic/irq_route.sv
`timescale 1ns/1ns
module irq_route (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Source select and sources
  input  wire logic sel_in,
  input  wire logic ext_in,
  input  wire logic busy_in,
  input  wire logic susp_in,
  // Shared channel
  output logic      chan_out
);

  logic busy_prev;
  logic eow;
  logic next_chan;

  // A suspend also drops busy but is no end of write
  assign eow = busy_prev & ~busy_in & ~susp_in;

  always_comb begin
    next_chan = sel_in ? eow : ext_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_prev <= 1'b0;
      chan_out  <= 1'b0;
    end else begin
      busy_prev <= busy_in;
      chan_out  <= next_chan;
    end
  end

endmodule

// >>> logic/flash_eeprom_write_status.sv
// Function
// - Select bit 0 routes external pin, 1 routes end-of-write onto channel.
// - Busy rises on first latched address (page) or on start (chip erase).
// - While busy, memory reads return FFh and writes are dropped.
// - Busy clears at end of write or on erase suspend.
// - Busy held high up to 10ms after power-up and power-down exit.
// - Error flag sets on any failed write; only software clears it.
// - Seven sector bits: bit 6 testflash, 5:4 eeprom, 3:0 flash F3..F0.
// - On large part bit 3 ORs F5, F4, F3; bits 2:0 map directly.
// - Sector bit meaning follows error, busy and suspend flags.
// - Erase failure sets erase fail bit, status one bit 7.
// - Program failure sets program fail bit, status one bit 6.
// - Clearing error flag clears erase, program and swap fail bits.
// - Flash 0-to-1 request sets swap bit, except protection programming.
// - Eeprom program failure during page swap sets swap bit.
// - After swap failure, skip erase of the old full sector.
// - Start bit launches op; device clears it; software clear not aborting.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module flash_eeprom_write_status
  import fe_status_pkg::*;
#(
  parameter bit BIG_FLASH = 1'b0,
  parameter int READY_CNT = READY_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 sys_rst_in,
  // Register port
  input  wire reg_req_t             reg_req_in,
  output logic [7:0]                reg_rdata_out,
  // Eeprom memory access
  input  wire mem_req_t             mem_req_in,
  input  wire logic [7:0]           mem_rdata_in,
  output logic [7:0]                mem_rdata_out,
  output logic                      mem_wr_out,
  // Write engine
  input  wire logic                 first_latch_in,
  input  wire logic                 eep_done_in,
  input  wire logic                 suspend_in,
  input  wire logic                 pd_exit_in,
  input  wire logic                 flash_busy_in,
  input  wire logic                 fail_valid_in,
  input  wire fail_evt_t            fail_in,
  input  wire logic [SECT_IN_W-1:0] active_sectors_in,
  input  wire logic                 swap_done_in,
  output logic                      write_active_out,
  output logic                      page_select_out,
  output logic                      chip_select_out,
  output logic                      skip_old_erase_out,
  output logic                      eeprom_busy_flag_out,
  // Interrupt channel
  input  wire logic                 ext_irq_in,
  output logic                      shared_irq_channel_out
);

  eep_state_t state;
  eep_state_t next_state;
  logic       ctl_start;
  logic       ctl_page;
  logic       ctl_chip;
  logic       ctl_irqsel;
  logic       next_start;
  logic       next_page;
  logic       next_chip;
  logic       next_irqsel;
  logic       err;
  logic [6:0] sect;
  logic       erase_fail;
  logic       prog_fail;
  logic       swap_fail;
  logic       skip_pend;
  logic       next_err;
  logic [6:0] next_sect;
  logic       next_erase_fail;
  logic       next_prog_fail;
  logic       next_swap_fail;
  logic       next_skip_pend;
  logic       next_skip;
  logic [7:0] next_rdata;
  logic [7:0] next_mem_rdata;
  logic       pu_busy;
  logic       busy;
  logic       wr_ctl;
  logic       wr_s0;
  logic       err_clear;

  assign wr_ctl    = reg_req_in.wr && reg_req_in.addr == CTRL_ADDR;
  assign wr_s0     = reg_req_in.wr && reg_req_in.addr == STAT0_ADDR;
  assign err_clear = wr_s0 && !reg_req_in.wdata[ERR_BIT];
  assign busy      = (state == EE_BUSY) || pu_busy;

  assign eeprom_busy_flag_out = busy;
  assign write_active_out     = state != EE_IDLE;
  assign page_select_out      = ctl_page;
  assign chip_select_out      = ctl_chip;
  assign mem_wr_out           = mem_req_in.wr && !busy;

  ready_timer #(
    .CNT (READY_CNT)
  ) ready_timer_inst (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .restart_in (pd_exit_in),
    .busy_out   (pu_busy)
  );

  irq_route irq_route_inst (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .sel_in     (ctl_irqsel),
    .ext_in     (ext_irq_in),
    .busy_in    (state == EE_BUSY || flash_busy_in),
    .susp_in    (suspend_in),
    .chan_out   (shared_irq_channel_out)
  );

  // Control register and engine sequencing
  always_comb begin
    next_state  = state;
    next_start  = ctl_start;
    next_page   = ctl_page;
    next_chip   = ctl_chip;
    next_irqsel = ctl_irqsel;
    if (wr_ctl) begin
      // Clearing start from software leaves the engine running
      next_start  = reg_req_in.wdata[START_BIT];
      next_page   = reg_req_in.wdata[PAGE_BIT];
      next_chip   = reg_req_in.wdata[CHIP_BIT];
      next_irqsel = reg_req_in.wdata[IRQSEL_BIT];
    end
    unique case (state)
      EE_IDLE: begin
        if (wr_ctl && reg_req_in.wdata[START_BIT] && !pu_busy) begin
          if (reg_req_in.wdata[CHIP_BIT]) begin
            next_state = EE_BUSY;
          end else if (reg_req_in.wdata[PAGE_BIT]) begin
            next_state = EE_WAIT_LATCH;
          end
        end
      end
      EE_WAIT_LATCH: begin
        if (first_latch_in) begin
          next_state = EE_BUSY;
        end
      end
      EE_BUSY: begin
        if (eep_done_in) begin
          next_state = EE_IDLE;
          next_start = 1'b0;
          next_page  = 1'b0;
          next_chip  = 1'b0;
        end else if (suspend_in) begin
          next_state = EE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state      <= EE_IDLE;
      ctl_start  <= CTRL_RST[START_BIT];
      ctl_page   <= CTRL_RST[PAGE_BIT];
      ctl_chip   <= CTRL_RST[CHIP_BIT];
      ctl_irqsel <= CTRL_RST[IRQSEL_BIT];
    end else begin
      state      <= next_state;
      ctl_start  <= next_start;
      ctl_page   <= next_page;
      ctl_chip   <= next_chip;
      ctl_irqsel <= next_irqsel;
    end
  end

  // Status registers, read data and memory read path
  always_comb begin
    next_err        = err;
    next_sect       = sect;
    next_erase_fail = erase_fail;
    next_prog_fail  = prog_fail;
    next_swap_fail  = swap_fail;
    next_skip_pend  = skip_pend;
    next_skip       = 1'b0;
    if (err_clear) begin
      next_err        = 1'b0;
      next_erase_fail = 1'b0;
      next_prog_fail  = 1'b0;
      next_swap_fail  = 1'b0;
    end
    // Error sectors stop tracking until the flag is cleared; later failures OR theirs in
    if (!next_err) begin
      next_sect = map_sectors(active_sectors_in, BIG_FLASH);
    end
    // Taken first so that a swap fail in the same cycle stays pending
    if (swap_done_in) begin
      next_skip      = skip_pend;
      next_skip_pend = 1'b0;
    end
    // A failure in the same cycle as the clear wins
    if (fail_valid_in) begin
      next_err = 1'b1;
      next_sect = (err && !err_clear ? sect : 7'h00)
                | map_sectors(fail_in.sectors, BIG_FLASH);
      if (fail_in.erase_fail) begin
        next_erase_fail = 1'b1;
      end
      if (fail_in.program_fail) begin
        next_prog_fail = 1'b1;
      end
      if (fail_in.overwrite_fail && !fail_in.prot_op) begin
        next_swap_fail = 1'b1;
      end
      if (fail_in.swap_fail) begin
        next_swap_fail = 1'b1;
        next_skip_pend = 1'b1;
      end
    end
    next_rdata = 8'h00;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        CTRL_ADDR:  next_rdata = {ctl_start, ctl_page, ctl_chip, 3'h0,
                                  ctl_irqsel, busy};
        STAT0_ADDR: next_rdata = {err, sect};
        STAT1_ADDR: next_rdata = {erase_fail, prog_fail, swap_fail, 5'h00};
        default:    next_rdata = 8'h00;
      endcase
    end
    next_mem_rdata = 8'h00;
    if (mem_req_in.rd) begin
      next_mem_rdata = busy ? BLANK_BYTE : mem_rdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      err                <= STAT0_RST[ERR_BIT];
      sect               <= STAT0_RST[SECT_MSB:0];
      erase_fail         <= STAT1_RST[ERASE_FAIL_BIT];
      prog_fail          <= STAT1_RST[PROG_FAIL_BIT];
      swap_fail          <= STAT1_RST[SWAP_FAIL_BIT];
      skip_pend          <= 1'b0;
      skip_old_erase_out <= 1'b0;
      reg_rdata_out      <= 8'h00;
      mem_rdata_out      <= 8'h00;
    end else begin
      err                <= next_err;
      sect               <= next_sect;
      erase_fail         <= next_erase_fail;
      prog_fail          <= next_prog_fail;
      swap_fail          <= next_swap_fail;
      skip_pend          <= next_skip_pend;
      skip_old_erase_out <= next_skip;
      reg_rdata_out      <= next_rdata;
      mem_rdata_out      <= next_mem_rdata;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_irq_ext_route: assert property (
    !ctl_irqsel |=> shared_irq_channel_out == $past(ext_irq_in))
    else $error("channel does not follow external pin");

  chk_chip_busy_rise: assert property (
    state == EE_IDLE && !pu_busy && wr_ctl && reg_req_in.wdata[START_BIT]
      && reg_req_in.wdata[CHIP_BIT] |=> busy && state == EE_BUSY)
    else $error("chip erase start did not raise busy");

  chk_blank_read: assert property (
    mem_req_in.rd && busy |=> mem_rdata_out == BLANK_BYTE)
    else $error("busy read did not return blank byte");

  chk_write_block: assert property (
    busy |-> !mem_wr_out)
    else $error("memory write passed while busy");

  chk_busy_clear: assert property (
    state == EE_BUSY && (eep_done_in || suspend_in) |=> state == EE_IDLE)
    else $error("busy did not clear at end or suspend");

  chk_ready_hold: assert property (
    $fell(sys_rst_in) |-> busy [*8])
    else $error("busy dropped early after power-up");

  chk_err_sticky: assert property (
    err && !err_clear |=> err)
    else $error("error flag lost without software clear");

  chk_cause_clear: assert property (
    err_clear && !fail_valid_in |=> !erase_fail && !prog_fail && !swap_fail)
    else $error("fail bits not cleared with error flag");

  chk_sector_track: assert property (
    !err && !fail_valid_in |=>
      sect == map_sectors($past(active_sectors_in), BIG_FLASH))
    else $error("sector bits do not track active sectors");

  chk_swap_skip: assert property (
    skip_pend && swap_done_in |=> skip_old_erase_out)
    else $error("old sector erase not skipped after swap fail");

  chk_start_clear: assert property (
    state == EE_BUSY && eep_done_in |=> !ctl_start)
    else $error("start bit not cleared at end of write");

  cov_page_update: cover property (
    state == EE_WAIT_LATCH ##1 state == EE_BUSY ##[1:200] state == EE_IDLE);
  cov_err_clear: cover property (err ##1 err_clear ##1 !err);
  cov_eow_irq: cover property (ctl_irqsel && shared_irq_channel_out);

endmodule

// >>> verif/host_cpu.sv
`timescale 1ns/1ns
module host_cpu
  import fe_status_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Requests
  output reg_req_t        reg_req_out,
  output mem_req_t        mem_req_out,
  // Answers
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic [7:0] mem_rdata_in,
  input  wire logic       mem_wr_in
);
  initial begin
    reg_req_out = '0;
    mem_req_out = '0;
  end

  // Host code lives outside the array, so only the register port steers it
  task automatic reg_wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    reg_req_out.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    reg_req_out.rd <= 1'b0;
    #1 d = reg_rdata_in;
  endtask

  task automatic mem_rd(output logic [7:0] d);
    @(posedge clk_in);
    mem_req_out.rd <= 1'b1;
    @(posedge clk_in);
    mem_req_out.rd <= 1'b0;
    #1 d = mem_rdata_in;
  endtask

  // Also used to blank a failed byte before retiring it
  task automatic mem_wr(output logic w);
    @(posedge clk_in);
    mem_req_out.wr <= 1'b1;
    #1 w = mem_wr_in;
    @(posedge clk_in);
    mem_req_out.wr <= 1'b0;
  endtask
endmodule

// >>> verif/test_flash_eeprom_write_status.sv
`timescale 1ns/1ns
module test_flash_eeprom_write_status;
  import fe_status_pkg::*;
  logic                 clk_in = 1'b0;
  logic                 sys_rst_in = 1'b1;
  reg_req_t             reg_req;
  mem_req_t             mem_req;
  logic [7:0]           reg_rdata;
  logic [7:0]           mem_rdata;
  logic                 mem_wr;
  logic [5:0]           ev = '0;
  logic                 flash_busy_flag = 1'b0;
  logic                 ext = 1'b0;
  fail_evt_t            fail = '0;
  logic [SECT_IN_W-1:0] act = '0;
  logic                 skip;
  logic                 busy;
  logic                 chan;
  logic                 wact;
  logic                 psel;
  logic                 csel;
  logic [7:0]           big_rdata;
  logic [7:0]           v;
  logic [7:0]           c;
  logic [7:0]           s;
  logic                 w;
  logic [7:0]           exp1 [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
  int                   n_fail = 0;
  int                   checks_done = 0;
  int                   cyc = 0;

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  flash_eeprom_write_status #(.READY_CNT(16)) flash_eeprom_write_status_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req),
    .reg_rdata_out(reg_rdata), .mem_req_in(mem_req), .mem_rdata_in(8'h5A),
    .mem_rdata_out(mem_rdata), .mem_wr_out(mem_wr), .first_latch_in(ev[0]),
    .eep_done_in(ev[1]), .suspend_in(ev[2]), .pd_exit_in(ev[3]),
    .flash_busy_in(flash_busy_flag), .fail_valid_in(ev[4]), .fail_in(fail),
    .active_sectors_in(act), .swap_done_in(ev[5]), .write_active_out(wact),
    .page_select_out(psel), .chip_select_out(csel), .skip_old_erase_out(skip),
    .eeprom_busy_flag_out(busy), .ext_irq_in(ext),
    .shared_irq_channel_out(chan));

  // Large-flash variant on the same stimulus, read back beside the first
  flash_eeprom_write_status #(.BIG_FLASH(1'b1), .READY_CNT(16))
    flash_eeprom_write_status_big_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req),
    .reg_rdata_out(big_rdata), .mem_req_in(mem_req), .mem_rdata_in(8'h5A),
    .mem_rdata_out(), .mem_wr_out(), .first_latch_in(ev[0]),
    .eep_done_in(ev[1]), .suspend_in(ev[2]), .pd_exit_in(ev[3]),
    .flash_busy_in(flash_busy_flag), .fail_valid_in(ev[4]), .fail_in(fail),
    .active_sectors_in(act), .swap_done_in(ev[5]), .write_active_out(),
    .page_select_out(), .chip_select_out(), .skip_old_erase_out(),
    .eeprom_busy_flag_out(), .ext_irq_in(ext),
    .shared_irq_channel_out());

  host_cpu host_cpu_inst (
    .clk_in(clk_in), .reg_req_out(reg_req), .mem_req_out(mem_req),
    .reg_rdata_in(reg_rdata), .mem_rdata_in(mem_rdata), .mem_wr_in(mem_wr));

  task automatic check(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic pulse(input int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
  endtask

  // Counts channel and skip pulses over six cycles
  task automatic watch(output logic [7:0] nc, ns);
    nc = 8'h00;
    ns = 8'h00;
    // First look lands just after the edge that ended the stimulus
    repeat (6) begin
      #1 nc += {7'h00, chan};
      ns += {7'h00, skip};
      @(posedge clk_in);
    end
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 check("busy after reset", {7'h00, busy}, 8'h01);
    host_cpu_inst.mem_rd(v);
    check("blocked read", v, BLANK_BYTE);
    host_cpu_inst.mem_wr(w);
    check("blocked write", {7'h00, w}, 8'h00);
    repeat (20) @(posedge clk_in);
    #1 check("ready", {7'h00, busy}, 8'h00);
    host_cpu_inst.mem_rd(v);
    check("normal read", v, 8'h5A);
    host_cpu_inst.reg_rd(STAT0_ADDR, v);
    check("status0 reset", v, STAT0_RST);
    host_cpu_inst.reg_rd(STAT1_ADDR, v);
    check("status1 reset", v, STAT1_RST);
    $display("test reset done");

    @(posedge clk_in);
    ext <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 check("pin routed", {7'h00, chan}, 8'h01);
    @(posedge clk_in);
    ext <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 check("pin low", {7'h00, chan}, 8'h00);
    $display("test routing done");

    // Chip erase with end-of-write routed; pin held high must not leak
    host_cpu_inst.reg_wr(CTRL_ADDR, 8'hA2);
    @(posedge clk_in);
    #1 check("erase busy", {7'h00, busy}, 8'h01);
    check("erase selects", {6'h00, wact, csel}, 8'h03);
    @(posedge clk_in);
    ext <= 1'b1;
    host_cpu_inst.reg_rd(CTRL_ADDR, v);
    check("ctrl in erase", v, 8'hA3);
    host_cpu_inst.mem_wr(w);
    check("write dropped", {7'h00, w}, 8'h00);
    host_cpu_inst.reg_wr(CTRL_ADDR, 8'h22);
    #1 check("start clear no abort", {7'h00, busy}, 8'h01);
    pulse(1);
    watch(c, s);
    check("end pulse count", c, 8'h01);
    check("busy after done", {7'h00, busy}, 8'h00);
    host_cpu_inst.reg_rd(CTRL_ADDR, v);
    check("ctrl after done", v, 8'h02);
    check("selects after done", {6'h00, wact, csel}, 8'h00);
    @(posedge clk_in);
    flash_busy_flag <= 1'b1;
    repeat (3) @(posedge clk_in);
    flash_busy_flag <= 1'b0;
    watch(c, s);
    check("flash end pulse", c, 8'h01);
    ext <= 1'b0;
    $display("test chip erase done");

    host_cpu_inst.reg_wr(CTRL_ADDR, 8'hC0);
    repeat (3) @(posedge clk_in);
    #1 check("page waits latch", {7'h00, busy}, 8'h00);
    check("page selects", {6'h00, wact, psel}, 8'h03);
    pulse(0);
    @(posedge clk_in);
    #1 check("page busy", {7'h00, busy}, 8'h01);
    pulse(2);
    @(posedge clk_in);
    #1 check("suspend frees", {7'h00, busy}, 8'h00);
    host_cpu_inst.reg_wr(CTRL_ADDR, 8'h00);
    $display("test page update done");

    // One failure kind per pass; the last is a protection overwrite
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      fail <= '{erase_fail: i == 0, program_fail: i == 1,
                overwrite_fail: i >= 2, prot_op: i == 3, swap_fail: 1'b0,
                sectors: 9'h081};
      pulse(4);
      host_cpu_inst.reg_wr(STAT0_ADDR, 8'h80);
      host_cpu_inst.reg_wr(STAT1_ADDR, 8'h00);
      host_cpu_inst.reg_rd(STAT0_ADDR, v);
      check("status0 fail", v, 8'hA1);
      host_cpu_inst.reg_rd(STAT1_ADDR, v);
      check("status1 cause", v, exp1[i]);
      host_cpu_inst.reg_wr(STAT0_ADDR, 8'h7F);
      host_cpu_inst.reg_rd(STAT1_ADDR, v);
      check("causes cleared", v, 8'h00);
    end
    @(posedge clk_in);
    fail <= '{swap_fail: 1'b1, sectors: 9'h080, default: 1'b0};
    pulse(4);
    host_cpu_inst.reg_rd(STAT1_ADDR, v);
    check("swap cause", v, 8'h20);
    pulse(5);
    watch(c, s);
    check("skip old erase", s, 8'h01);
    host_cpu_inst.mem_wr(w);
    check("blank rewrite", {7'h00, w}, 8'h01);
    host_cpu_inst.reg_wr(STAT0_ADDR, 8'h00);
    host_cpu_inst.reg_rd(STAT0_ADDR, v);
    check("error cleared", v, 8'h00);
    $display("test status done");

    @(posedge clk_in);
    act <= 9'h100;
    repeat (2) @(posedge clk_in);
    host_cpu_inst.reg_rd(STAT0_ADDR, v);
    check("testflash sector", v, 8'h40);
    @(posedge clk_in);
    act <= 9'h008;
    repeat (2) @(posedge clk_in);
    host_cpu_inst.reg_rd(STAT0_ADDR, v);
    check("sector F3", v, 8'h08);
    check("large F3", big_rdata, 8'h08);
    @(posedge clk_in);
    act <= 9'h010;
    repeat (2) @(posedge clk_in);
    host_cpu_inst.reg_rd(STAT0_ADDR, v);
    check("small F4", v, 8'h00);
    check("large F4", big_rdata, 8'h08);
    @(posedge clk_in);
    act <= '0;
    pulse(3);
    @(posedge clk_in);
    #1 check("wake busy", {7'h00, busy}, 8'h01);
    repeat (20) @(posedge clk_in);
    #1 check("wake ready", {7'h00, busy}, 8'h00);
    $display("test sectors and wake done");
    test_done();
  end
endmodule
